// *** logic/tdbu_debug_unit.sv ***
// tile debug breakpoint unit: breakpoints, watchpoints, debug line, scratch
// Function
// - data watch hit captures address; resource watch hit with no data watch hit captures id
// - eight-bit stop mask halts set threads whenever tile 0 is not in debug mode
// - eight scratch words shared by debug code and debugger, two spaces
// - four instruction breakpoint addresses compared with pc raise interrupt
// - control bits 23:16 enable per thread, reset to zero
// - instruction control bit 1 chooses break on equal or not equal
// - control bit 0 enables the breakpoint, resets to zero
// - four data watchpoints with two addresses and a control each
// - data control bit 2 makes the watchpoint fire on loads
// - data control bit 1 combines conditions: clear is and, set is or
// - four resource watchpoints with mask, value and control words
// - pin config bit 1 lets shared line request debug of that tile
// - pin config bit 0 lets tile debug flag drive shared line
// - origin register records latest line event: bit4 pin, bits1,0 tiles
// - security bit 0 blocks debugger access from outside
`include "tdbu_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tdbu_debug_unit (
   input wire logic clk_sys,
   input wire logic rst_n,
   // register access port
   input wire tdbu_pkg::tdbu_space_t reg_space,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire tdbu_pkg::tdbu_word_t reg_wdata,
   output tdbu_pkg::tdbu_word_t reg_rdata,
   output logic reg_rvalid,
   // pipeline observation
   input wire logic pc_valid,
   input wire tdbu_pkg::tdbu_word_t pc,
   input wire tdbu_pkg::tdbu_thread_t pc_thread,
   input wire logic mem_valid,
   input wire logic mem_is_load,
   input wire tdbu_pkg::tdbu_word_t mem_addr,
   input wire tdbu_pkg::tdbu_thread_t mem_thread,
   input wire logic res_valid,
   input wire tdbu_pkg::tdbu_word_t res_id,
   input wire tdbu_pkg::tdbu_thread_t res_thread,
   output logic dbg_irq,
   output tdbu_pkg::tdbu_thread_t dbg_irq_thread,
   output logic [7:0] thread_stop,
   // shared debug line and tiles
   input wire logic [1:0] tile_in_debug_flag,
   input wire logic shared_debug_line_n_in,
   output logic shared_debug_line_n_out,
   output logic shared_debug_line_n_oe,
   output logic [1:0] tile_debug_req,
   // security copy
   input wire logic sec_jtag_disable,
   input wire logic jtag_access_req,
   output logic jtag_access_grant
);
   import tdbu_pkg::*;

   tdbu_word_t ib_addr_reg [4];
   tdbu_word_t ib_ctrl_reg [4];
   tdbu_word_t dw_addr1_reg [4];
   tdbu_word_t dw_addr2_reg [4];
   tdbu_word_t dw_ctrl_reg [4];
   tdbu_word_t rw_mask_reg [4];
   tdbu_word_t rw_value_reg [4];
   tdbu_word_t rw_ctrl_reg [4];
   tdbu_word_t capture_reg;
   tdbu_word_t stop_reg;
   tdbu_word_t pin_cfg_reg [2];
   tdbu_word_t origin_reg;
   tdbu_word_t rdata_reg;
   tdbu_word_t rd_next;
   tdbu_word_t scratch_rdata;
   logic scratch_sel_reg;
   logic [3:0] ib_hit;
   logic [3:0] dw_hit;
   logic [3:0] rw_hit;
   logic line_low_reg;
   logic line_event;
   logic [1:0] tile_drive;

   // decode
   logic ps_acc;
   logic sw_acc;
   logic tc_acc;
   logic [1:0] idx;
   logic scratch_hit;
   assign ps_acc = (reg_space == TDBU_SPACE_PS);
   assign sw_acc = (reg_space == TDBU_SPACE_SWITCH);
   // refused outside access when secured: reads give zero, writes dropped
   assign tc_acc = (reg_space == TDBU_SPACE_TCFG)
      && !sec_jtag_disable;
   assign idx = reg_addr[1:0];
   assign scratch_hit = ((reg_addr & `TDBU_GROUP8_MASK) == `TDBU_OFF_SCRATCH
      && ps_acc) || ((reg_addr & `TDBU_GROUP8_MASK) == `TDBU_OFF_TCFG_SCRATCH
      && tc_acc);
   assign jtag_access_grant = jtag_access_req && !sec_jtag_disable;

   function automatic logic grp(input logic [7:0] a, input logic [7:0] base);
      grp = ((a & `TDBU_GROUP4_MASK) == base);
   endfunction

   tdbu_scratch_mem u_scratch (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wr_en(reg_wr && scratch_hit),
      .rd_en(reg_rd && scratch_hit),
      .index(reg_addr[2:0]),
      .wdata(reg_wdata),
      .rdata(scratch_rdata)
   );

   // match logic, one lane per breakpoint index
   for (genvar i = 0; i < 4; i++) begin : g_match
      logic [7:0] ib_tm;
      logic [7:0] dw_tm;
      logic [7:0] rw_tm;
      logic cond_a;
      logic cond_b;
      logic dw_cond;
      assign ib_tm = ib_ctrl_reg[i][`TDBU_FLD_TMASK_HI:`TDBU_FLD_TMASK_LO];
      assign dw_tm = dw_ctrl_reg[i][`TDBU_FLD_TMASK_HI:`TDBU_FLD_TMASK_LO];
      assign rw_tm = rw_ctrl_reg[i][`TDBU_FLD_TMASK_HI:`TDBU_FLD_TMASK_LO];
      assign ib_hit[i] = pc_valid && ib_ctrl_reg[i][`TDBU_FLD_ENABLE]
         && ib_tm[pc_thread]
         && (ib_ctrl_reg[i][`TDBU_FLD_NOTEQ] ? (pc != ib_addr_reg[i])
            : (pc == ib_addr_reg[i]));
      assign cond_a = (mem_addr == dw_addr1_reg[i]);
      assign cond_b = (mem_addr == dw_addr2_reg[i]);
      assign dw_cond = dw_ctrl_reg[i][`TDBU_FLD_ANY] ? (cond_a || cond_b)
         : (cond_a && cond_b);
      // loads when bit 2 set, stores when clear
      assign dw_hit[i] = mem_valid && dw_ctrl_reg[i][`TDBU_FLD_ENABLE]
         && dw_tm[mem_thread] && dw_cond
         && (mem_is_load == dw_ctrl_reg[i][`TDBU_FLD_LOADS]);
      assign rw_hit[i] = res_valid && rw_ctrl_reg[i][`TDBU_FLD_ENABLE]
         && rw_tm[res_thread]
         && ((res_id & rw_mask_reg[i]) ==
            (rw_value_reg[i] & rw_mask_reg[i]));
   end

   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            ib_addr_reg[i] <= `TDBU_RST_WORD;
            ib_ctrl_reg[i] <= `TDBU_RST_WORD;
            dw_addr1_reg[i] <= `TDBU_RST_WORD;
            dw_addr2_reg[i] <= `TDBU_RST_WORD;
            dw_ctrl_reg[i] <= `TDBU_RST_WORD;
            rw_mask_reg[i] <= `TDBU_RST_WORD;
            rw_value_reg[i] <= `TDBU_RST_WORD;
            rw_ctrl_reg[i] <= `TDBU_RST_WORD;
         end
         stop_reg <= `TDBU_RST_WORD;
      end else if (reg_wr && ps_acc) begin
         if (grp(reg_addr, `TDBU_OFF_IB_ADDR)) begin
            ib_addr_reg[idx] <= reg_wdata;
         end
         if (grp(reg_addr, `TDBU_OFF_IB_CTRL)) begin
            ib_ctrl_reg[idx] <= reg_wdata & `TDBU_WM_IB_CTRL;
         end
         if (grp(reg_addr, `TDBU_OFF_DW_ADDR1)) begin
            dw_addr1_reg[idx] <= reg_wdata;
         end
         if (grp(reg_addr, `TDBU_OFF_DW_ADDR2)) begin
            dw_addr2_reg[idx] <= reg_wdata;
         end
         if (grp(reg_addr, `TDBU_OFF_DW_CTRL)) begin
            dw_ctrl_reg[idx] <= reg_wdata & `TDBU_WM_DW_CTRL;
         end
         if (grp(reg_addr, `TDBU_OFF_RW_MASK)) begin
            rw_mask_reg[idx] <= reg_wdata;
         end
         if (grp(reg_addr, `TDBU_OFF_RW_VALUE)) begin
            rw_value_reg[idx] <= reg_wdata;
         end
         if (grp(reg_addr, `TDBU_OFF_RW_CTRL)) begin
            rw_ctrl_reg[idx] <= reg_wdata & `TDBU_WM_RW_CTRL;
         end
         if (reg_addr == `TDBU_OFF_STOP) begin
            stop_reg <= reg_wdata & `TDBU_WM_STOP;
         end
      end
   end

   // threads named in the stop mask may only run while tile 0 is in debug mode
   assign thread_stop = tile_in_debug_flag[0] ? 8'h00 : stop_reg[7:0];

   // interrupt raise and capture; a hit beats a software write
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         capture_reg <= `TDBU_RST_WORD;
         dbg_irq <= 1'b0;
         dbg_irq_thread <= '0;
      end else begin
         dbg_irq <= |{ib_hit, dw_hit, rw_hit};
         if (|ib_hit) begin
            dbg_irq_thread <= pc_thread;
         end else if (|dw_hit) begin
            dbg_irq_thread <= mem_thread;
         end else if (|rw_hit) begin
            dbg_irq_thread <= res_thread;
         end
         if (|dw_hit) begin
            capture_reg <= mem_addr;
         end else if (|rw_hit) begin
            capture_reg <= res_id;
         end else if (reg_wr && ps_acc && reg_addr == `TDBU_OFF_CAPTURE) begin
            capture_reg <= reg_wdata;
         end
      end
   end

   // shared debug line, active low, open drain
   for (genvar t = 0; t < 2; t++) begin : g_tile
      assign tile_drive[t] = pin_cfg_reg[t][`TDBU_FLD_PIN_DRIVE]
         && tile_in_debug_flag[t];
      assign tile_debug_req[t] = pin_cfg_reg[t][`TDBU_FLD_PIN_REQ]
         && !shared_debug_line_n_in;
   end
   assign shared_debug_line_n_out = 1'b0;
   assign shared_debug_line_n_oe = |tile_drive;
   assign line_event = !shared_debug_line_n_in && !line_low_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_cfg_reg[0] <= `TDBU_RST_WORD;
         pin_cfg_reg[1] <= `TDBU_RST_WORD;
         origin_reg <= `TDBU_RST_WORD;
         line_low_reg <= 1'b0;
      end else begin
         line_low_reg <= !shared_debug_line_n_in;
         if (reg_wr && sw_acc && reg_addr == `TDBU_OFF_PIN_CFG0) begin
            pin_cfg_reg[0] <= reg_wdata & `TDBU_WM_PIN_CFG;
         end
         if (reg_wr && sw_acc && reg_addr == `TDBU_OFF_PIN_CFG1) begin
            pin_cfg_reg[1] <= reg_wdata & `TDBU_WM_PIN_CFG;
         end
         // a new event overwrites whatever software left there
         if (line_event) begin
            origin_reg <= {27'h0000000, ~|tile_drive, 2'b00,
               tile_drive};
         end else if (reg_wr && sw_acc && reg_addr == `TDBU_OFF_ORIGIN) begin
            origin_reg <= reg_wdata & `TDBU_WM_ORIGIN;
         end
      end
   end

   // read path
   always_comb begin
      rd_next = `TDBU_RST_WORD;
      if (ps_acc) begin
         if (reg_addr == `TDBU_OFF_CAPTURE) rd_next = capture_reg;
         if (reg_addr == `TDBU_OFF_STOP) rd_next = stop_reg;
         if (grp(reg_addr, `TDBU_OFF_IB_ADDR)) rd_next = ib_addr_reg[idx];
         if (grp(reg_addr, `TDBU_OFF_IB_CTRL)) rd_next = ib_ctrl_reg[idx];
         if (grp(reg_addr, `TDBU_OFF_DW_ADDR1)) rd_next = dw_addr1_reg[idx];
         if (grp(reg_addr, `TDBU_OFF_DW_ADDR2)) rd_next = dw_addr2_reg[idx];
         if (grp(reg_addr, `TDBU_OFF_DW_CTRL)) rd_next = dw_ctrl_reg[idx];
         if (grp(reg_addr, `TDBU_OFF_RW_MASK)) rd_next = rw_mask_reg[idx];
         if (grp(reg_addr, `TDBU_OFF_RW_VALUE)) rd_next = rw_value_reg[idx];
         if (grp(reg_addr, `TDBU_OFF_RW_CTRL)) rd_next = rw_ctrl_reg[idx];
      end else if (sw_acc) begin
         if (reg_addr == `TDBU_OFF_PIN_CFG0) rd_next = pin_cfg_reg[0];
         if (reg_addr == `TDBU_OFF_PIN_CFG1) rd_next = pin_cfg_reg[1];
         if (reg_addr == `TDBU_OFF_ORIGIN) rd_next = origin_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_reg <= `TDBU_RST_WORD;
         scratch_sel_reg <= 1'b0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            rdata_reg <= rd_next;
            scratch_sel_reg <= scratch_hit;
         end
      end
   end
   // both sources are flops; the select only picks one
   assign reg_rdata = scratch_sel_reg ? scratch_rdata : rdata_reg;

   // checks
   a_stop_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !tile_in_debug_flag[0] |-> thread_stop == stop_reg[7:0])
      else $error("stop mask not applied outside debug");
   a_capture_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      |dw_hit |=> capture_reg == $past(mem_addr))
      else $error("data watch address not captured");
   a_capture_res: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (|rw_hit && !(|dw_hit)) |=> capture_reg == $past(res_id))
      else $error("resource id not captured");
   a_ib_equal: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pc_valid && ib_ctrl_reg[0][0] && !ib_ctrl_reg[0][1]
      && ib_ctrl_reg[0][16 + pc_thread] && pc == ib_addr_reg[0]
      |=> dbg_irq && dbg_irq_thread == $past(pc_thread))
      else $error("equal breakpoint did not interrupt");
   a_ib_noteq: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ib_hit[1] && ib_ctrl_reg[1][1] |-> pc != ib_addr_reg[1])
      else $error("not-equal breakpoint fired on equal pc");
   a_mask_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dw_ctrl_reg[0][23:16] == 8'h00 |-> !dw_hit[0])
      else $error("watchpoint fired with empty thread mask");
   a_dw_and: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dw_hit[2] && !dw_ctrl_reg[2][1] |-> mem_addr == dw_addr1_reg[2]
      && mem_addr == dw_addr2_reg[2])
      else $error("and-combined watchpoint fired on one condition");
   a_dw_kind: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dw_hit[2] |-> mem_is_load == dw_ctrl_reg[2][2])
      else $error("watchpoint fired on wrong access kind");
   a_rw_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rw_hit[3] |-> ((res_id ^ rw_value_reg[3]) & rw_mask_reg[3]) == 0
      && rw_ctrl_reg[3][0])
      else $error("resource watch fired without match");
   a_line_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tile_debug_req[1] |-> !shared_debug_line_n_in
      && pin_cfg_reg[1][1])
      else $error("debug request without line and enable");
   a_line_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tile_in_debug_flag[0] && pin_cfg_reg[0][0]
      |-> shared_debug_line_n_oe)
      else $error("tile in debug did not drive line");
   a_origin_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
      line_event && !(|tile_drive) |=> origin_reg == 32'h00000010)
      else $error("external origin not recorded");
   a_jtag_refuse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_space == TDBU_SPACE_TCFG && sec_jtag_disable
      |=> reg_rvalid && reg_rdata == 32'h0)
      else $error("secured space returned data");
endmodule
`default_nettype wire

// *** logic/tdbu_consts.svh ***
// offsets, field positions, write masks and reset values of the debug unit
`ifndef TDBU_CONSTS_SVH
`define TDBU_CONSTS_SVH
// processor-status space
`define TDBU_OFF_CAPTURE 8'h16
`define TDBU_OFF_STOP 8'h18
`define TDBU_OFF_SCRATCH 8'h20
`define TDBU_OFF_IB_ADDR 8'h30
`define TDBU_OFF_IB_CTRL 8'h40
`define TDBU_OFF_DW_ADDR1 8'h50
`define TDBU_OFF_DW_ADDR2 8'h60
`define TDBU_OFF_DW_CTRL 8'h70
`define TDBU_OFF_RW_MASK 8'h80
`define TDBU_OFF_RW_VALUE 8'h90
`define TDBU_OFF_RW_CTRL 8'h9c
// switch space
`define TDBU_OFF_PIN_CFG0 8'h10
`define TDBU_OFF_PIN_CFG1 8'h11
`define TDBU_OFF_ORIGIN 8'h1f
// tile configuration space
`define TDBU_OFF_TCFG_SCRATCH 8'h20
// decode masks
`define TDBU_GROUP4_MASK 8'hfc
`define TDBU_GROUP8_MASK 8'hf8
// field positions
`define TDBU_FLD_ENABLE 0
`define TDBU_FLD_NOTEQ 1
`define TDBU_FLD_ANY 1
`define TDBU_FLD_LOADS 2
`define TDBU_FLD_TMASK_HI 23
`define TDBU_FLD_TMASK_LO 16
`define TDBU_FLD_PIN_DRIVE 0
`define TDBU_FLD_PIN_REQ 1
`define TDBU_FLD_ORG_EXT 4
// writable bits
`define TDBU_WM_IB_CTRL 32'h00ff0003
`define TDBU_WM_DW_CTRL 32'h00ff0007
`define TDBU_WM_RW_CTRL 32'h00ff0001
`define TDBU_WM_STOP 32'h000000ff
`define TDBU_WM_PIN_CFG 32'h00000003
`define TDBU_WM_ORIGIN 32'h00000013
`define TDBU_RST_WORD 32'h00000000
`endif

// *** logic/tdbu_pkg.sv ***
// types shared by the debug unit files
package tdbu_pkg;
   typedef enum logic [1:0] {
      TDBU_SPACE_PS,
      TDBU_SPACE_SWITCH,
      TDBU_SPACE_TCFG,
      TDBU_SPACE_NONE
   } tdbu_space_t;
   typedef logic [31:0] tdbu_word_t;
   typedef logic [2:0] tdbu_thread_t;
endpackage

// *** logic/tdbu_scratch_mem.sv ***
// eight-word scratch store with registered read data
`timescale 1ns/1ps
`default_nettype none
module tdbu_scratch_mem (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [2:0] index,
   input wire tdbu_pkg::tdbu_word_t wdata,
   output tdbu_pkg::tdbu_word_t rdata
);
   import tdbu_pkg::*;
   tdbu_word_t mem_reg [8];
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < 8; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (wr_en) begin
         mem_reg[index] <= wdata;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (rd_en) begin
         rdata <= mem_reg[index];
      end
   end
endmodule
`default_nettype wire

// *** testbench/tdbu_pipe_model.sv ***
// pipeline and shared debug line model facing the debug unit
`timescale 1ns/1ps
`default_nettype none
module tdbu_pipe_model (
   input wire logic clk_sys,
   input wire logic line_n_oe,
   input wire logic line_n_out,
   input wire logic ext_pull_low,
   output logic line_n,
   output logic pc_valid,
   output tdbu_pkg::tdbu_word_t pc,
   output tdbu_pkg::tdbu_thread_t pc_thread,
   output logic mem_valid,
   output logic mem_is_load,
   output tdbu_pkg::tdbu_word_t mem_addr,
   output tdbu_pkg::tdbu_thread_t mem_thread,
   output logic res_valid,
   output tdbu_pkg::tdbu_word_t res_id,
   output tdbu_pkg::tdbu_thread_t res_thread
);
   import tdbu_pkg::*;
   // open drain with pull-up: idle high, any driver pulls it low
   assign line_n = !((line_n_oe && !line_n_out) || ext_pull_low);
   initial begin
      pc_valid = 1'b0;
      mem_valid = 1'b0;
      res_valid = 1'b0;
      pc = 32'h0;
      pc_thread = 3'h0;
      mem_is_load = 1'b0;
      mem_addr = 32'h0;
      mem_thread = 3'h0;
      res_id = 32'h0;
      res_thread = 3'h0;
   end
   // each op is valid for one cycle; stale fields are inverted so a
   // design that samples outside valid sees garbage, not the last value
   task automatic pc_op(input tdbu_word_t a, input tdbu_thread_t t);
      pc = a;
      pc_thread = t;
      pc_valid = 1'b1;
      @(negedge clk_sys);
      pc_valid = 1'b0;
      pc = ~a;
      pc_thread = ~t;
   endtask
   task automatic mem_op(input tdbu_word_t a, input tdbu_thread_t t,
                         input logic ld);
      mem_addr = a;
      mem_thread = t;
      mem_is_load = ld;
      mem_valid = 1'b1;
      @(negedge clk_sys);
      mem_valid = 1'b0;
      mem_addr = ~a;
      mem_thread = ~t;
      mem_is_load = ~ld;
   endtask
   task automatic res_op(input tdbu_word_t a, input tdbu_thread_t t);
      res_id = a;
      res_thread = t;
      res_valid = 1'b1;
      @(negedge clk_sys);
      res_valid = 1'b0;
      res_id = ~a;
      res_thread = ~t;
   endtask
endmodule
`default_nettype wire

// *** testbench/tile_debug_breakpoint_unit_bench.sv ***
// self-checking bench for the tile debug unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   compares++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
   end \
end
module tile_debug_breakpoint_unit_bench;
   import tdbu_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   tdbu_space_t reg_space = TDBU_SPACE_NONE;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   tdbu_word_t reg_wdata = 32'h0;
   tdbu_word_t reg_rdata;
   logic reg_rvalid;
   logic pc_valid, mem_valid, mem_is_load, res_valid, line_n;
   tdbu_word_t pc, mem_addr, res_id;
   tdbu_thread_t pc_thread, mem_thread, res_thread, dbg_irq_thread;
   logic dbg_irq, line_n_out, line_n_oe, jtag_access_grant;
   logic [7:0] thread_stop;
   logic [1:0] tile_debug_req;
   logic [1:0] in_debug = 2'b00;
   logic ext_low = 1'b0;
   logic sec_dis = 1'b0;
   logic jtag_req = 1'b1;
   int mismatches = 0;
   int compares = 0;
   always #12.5 clk_sys = ~clk_sys;
   tdbu_debug_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_space(reg_space), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .pc_valid(pc_valid), .pc(pc),
      .pc_thread(pc_thread), .mem_valid(mem_valid),
      .mem_is_load(mem_is_load), .mem_addr(mem_addr),
      .mem_thread(mem_thread), .res_valid(res_valid), .res_id(res_id),
      .res_thread(res_thread), .dbg_irq(dbg_irq),
      .dbg_irq_thread(dbg_irq_thread), .thread_stop(thread_stop),
      .tile_in_debug_flag(in_debug), .shared_debug_line_n_in(line_n),
      .shared_debug_line_n_out(line_n_out),
      .shared_debug_line_n_oe(line_n_oe), .tile_debug_req(tile_debug_req),
      .sec_jtag_disable(sec_dis), .jtag_access_req(jtag_req),
      .jtag_access_grant(jtag_access_grant));
   tdbu_pipe_model pm_u (.clk_sys(clk_sys), .line_n_oe(line_n_oe),
      .line_n_out(line_n_out), .ext_pull_low(ext_low), .line_n(line_n),
      .pc_valid(pc_valid), .pc(pc), .pc_thread(pc_thread),
      .mem_valid(mem_valid), .mem_is_load(mem_is_load),
      .mem_addr(mem_addr), .mem_thread(mem_thread), .res_valid(res_valid),
      .res_id(res_id), .res_thread(res_thread));
   task automatic give_verdict();
      if (mismatches == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(input tdbu_space_t s, input logic [7:0] a,
                     input tdbu_word_t d);
      reg_space = s;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic rd(input tdbu_space_t s, input logic [7:0] a,
                     input tdbu_word_t e);
      reg_space = s;
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      `CHK(reg_rvalid, 1'b1)
      `CHK(reg_rdata, e)
      reg_rd = 1'b0;
      @(negedge clk_sys);
   endtask
   // looked at in the one cycle that the interrupt pulse stands
   task automatic hit(input logic e, input tdbu_thread_t t);
      `CHK(dbg_irq, e)
      if (e) begin
         `CHK(dbg_irq_thread, t)
      end
      @(negedge clk_sys);
   endtask
   task automatic t_reset_and_masks();
      logic [7:0] offs [5] = '{8'h41, 8'h72, 8'h9d, 8'h18, 8'h01};
      tdbu_word_t msk [5] = '{32'h00ff0003, 32'h00ff0007, 32'h00ff0001,
                              32'h000000ff, 32'h0};
      rd(TDBU_SPACE_PS, 8'h40, 32'h0);
      rd(TDBU_SPACE_PS, 8'h70, 32'h0);
      rd(TDBU_SPACE_SWITCH, 8'h10, 32'h0);
      rd(TDBU_SPACE_SWITCH, 8'h11, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr(TDBU_SPACE_PS, offs[i], 32'hffffffff);
         rd(TDBU_SPACE_PS, offs[i], msk[i]);
         wr(TDBU_SPACE_PS, offs[i], 32'h0);
      end
      wr(TDBU_SPACE_SWITCH, 8'h1f, 32'hffffffff);
      rd(TDBU_SPACE_SWITCH, 8'h1f, 32'h00000013);
      wr(TDBU_SPACE_SWITCH, 8'h1f, 32'h0);
   endtask
   task automatic t_scratch();
      for (int i = 0; i < 8; i++) begin
         wr(TDBU_SPACE_PS, 8'h20 + 8'(i), 32'ha5a50000 | i);
      end
      for (int i = 0; i < 8; i++) begin
         rd(TDBU_SPACE_TCFG, 8'h20 + 8'(i), 32'ha5a50000 | i);
      end
      wr(TDBU_SPACE_TCFG, 8'h27, 32'h5a5a0707);
      rd(TDBU_SPACE_PS, 8'h27, 32'h5a5a0707);
      sec_dis = 1'b1;
      #1 `CHK(jtag_access_grant, 1'b0)
      rd(TDBU_SPACE_TCFG, 8'h20, 32'h0);
      wr(TDBU_SPACE_TCFG, 8'h21, 32'h12345678);
      sec_dis = 1'b0;
      #1 `CHK(jtag_access_grant, 1'b1)
      rd(TDBU_SPACE_PS, 8'h21, 32'ha5a50001);
   endtask
   task automatic t_ibreak();
      tdbu_word_t a;
      for (int i = 0; i < 4; i++) begin
         a = 32'h1000 + 32'(i * 16);
         wr(TDBU_SPACE_PS, 8'h30 + 8'(i), a);
         wr(TDBU_SPACE_PS, 8'h40 + 8'(i), (32'h00010000 << i) | 32'h1);
         pm_u.pc_op(a, 3'(i));
         hit(1'b1, 3'(i));
         pm_u.pc_op(a, 3'(i + 4));
         hit(1'b0, 3'h0);
         wr(TDBU_SPACE_PS, 8'h40 + 8'(i), 32'h0);
         pm_u.pc_op(a, 3'(i));
         hit(1'b0, 3'h0);
      end
      wr(TDBU_SPACE_PS, 8'h41, 32'h00010003);
      pm_u.pc_op(32'h1010, 3'h0);
      hit(1'b0, 3'h0);
      pm_u.pc_op(32'h1014, 3'h0);
      hit(1'b1, 3'h0);
      wr(TDBU_SPACE_PS, 8'h41, 32'h0);
   endtask
   task automatic t_dwatch();
      wr(TDBU_SPACE_PS, 8'h52, 32'h200);
      wr(TDBU_SPACE_PS, 8'h62, 32'h300);
      wr(TDBU_SPACE_PS, 8'h72, 32'h00080005);
      pm_u.mem_op(32'h200, 3'h3, 1'b1);
      hit(1'b0, 3'h0);
      wr(TDBU_SPACE_PS, 8'h72, 32'h00080007);
      pm_u.mem_op(32'h300, 3'h3, 1'b1);
      hit(1'b1, 3'h3);
      rd(TDBU_SPACE_PS, 8'h16, 32'h300);
      pm_u.mem_op(32'h300, 3'h3, 1'b0);
      hit(1'b0, 3'h0);
      pm_u.mem_op(32'h300, 3'h2, 1'b1);
      hit(1'b0, 3'h0);
      wr(TDBU_SPACE_PS, 8'h72, 32'h0);
   endtask
   task automatic t_rwatch();
      wr(TDBU_SPACE_PS, 8'h83, 32'h0000ff00);
      wr(TDBU_SPACE_PS, 8'h93, 32'h000012ff);
      wr(TDBU_SPACE_PS, 8'h9f, 32'h00200001);
      pm_u.res_op(32'h000012ab, 3'h5);
      hit(1'b1, 3'h5);
      rd(TDBU_SPACE_PS, 8'h16, 32'h000012ab);
      pm_u.res_op(32'h000013ab, 3'h5);
      hit(1'b0, 3'h0);
      pm_u.res_op(32'h000012ab, 3'h4);
      hit(1'b0, 3'h0);
      wr(TDBU_SPACE_PS, 8'h9f, 32'h0);
   endtask
   task automatic t_stop_and_line();
      wr(TDBU_SPACE_PS, 8'h18, 32'h000000a5);
      `CHK(thread_stop, 8'ha5)
      wr(TDBU_SPACE_SWITCH, 8'h10, 32'h3);
      in_debug = 2'b01;
      #1 `CHK(thread_stop, 8'h00)
      `CHK(line_n_oe, 1'b1)
      `CHK(tile_debug_req, 2'b01)
      repeat (2) @(negedge clk_sys);
      rd(TDBU_SPACE_SWITCH, 8'h1f, 32'h1);
      in_debug = 2'b00;
      @(negedge clk_sys);
      ext_low = 1'b1;
      repeat (2) @(negedge clk_sys);
      rd(TDBU_SPACE_SWITCH, 8'h1f, 32'h10);
      ext_low = 1'b0;
      wr(TDBU_SPACE_SWITCH, 8'h11, 32'h3);
      in_debug = 2'b10;
      #1 `CHK(tile_debug_req, 2'b11)
      `CHK(thread_stop, 8'ha5)
      repeat (2) @(negedge clk_sys);
      rd(TDBU_SPACE_SWITCH, 8'h1f, 32'h2);
      in_debug = 2'b00;
      wr(TDBU_SPACE_SWITCH, 8'h10, 32'h2);
      in_debug = 2'b01;
      #1 `CHK(line_n_oe, 1'b0)
      `CHK(tile_debug_req, 2'b00)
      in_debug = 2'b00;
      #1 `CHK(thread_stop, 8'ha5)
   endtask
   // a hang ends the run as a failure
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      t_reset_and_masks();
      t_scratch();
      t_ibreak();
      t_dwatch();
      t_rwatch();
      t_stop_and_line();
      give_verdict();
   end
endmodule
`default_nettype wire
